//--- hdl/msr_pkg.sv
// Functional notes
// RULE_01 - Data-ready open drain, low 250 us
// RULE_02 - Measure config field picks self-test polarity
// RULE_03 - Set, ambient, bias, biased; store difference
// RULE_04 - Serial slave only, fixed 7-bit address
// RULE_05 - Standard and fast rate; no high speed
// RULE_06 - Host accesses served before measurement work
// RULE_07 - Internal clock only, never on a pin
// RULE_08 - Host may poll instead of watching strobe
// RULE_09 - Slave address 0x1E; 0x3D read, 0x3C write
// RULE_10 - Measure config field is bits 1:0
// RULE_11 - Self-test completion pulses data-ready too
package msr_pkg;

	localparam logic [6:0] SLAVE_ADDR = 7'h1E;

	localparam logic [7:0] REG_CRA  = 8'h00;
	localparam logic [7:0] REG_CRB  = 8'h01;
	localparam logic [7:0] REG_MODE = 8'h02;
	localparam logic [7:0] REG_DXH  = 8'h03;
	localparam logic [7:0] REG_DYL  = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h09;
	localparam logic [7:0] REG_IDA  = 8'h0A;
	localparam logic [7:0] REG_IDB  = 8'h0B;
	localparam logic [7:0] REG_IDC  = 8'h0C;

	localparam logic [7:0] CRA_RST  = 8'h10;
	localparam logic [7:0] CRA_MASK = 8'h7F;
	localparam logic [7:0] CRB_RST  = 8'h20;
	localparam logic [7:0] MODE_RST = 8'h01;
	localparam logic [7:0] MODE_MASK = 8'h03;

	localparam int MS_LSB = 0;
	localparam logic [1:0] MS_NORMAL = 2'h0;
	localparam logic [1:0] MS_POS    = 2'h1;
	localparam logic [1:0] MS_NEG    = 2'h2;

	localparam logic [1:0] MD_CONT   = 2'h0;
	localparam logic [1:0] MD_SINGLE = 2'h1;
	localparam logic [1:0] MD_IDLE   = 2'h2;

	localparam int STAT_RDY  = 0;
	localparam int STAT_BUSY = 1;

	localparam int CLK_MHZ      = 125;
	localparam int RESULT_READY_STROBE_N_US      = 250;
	localparam int RESULT_READY_STROBE_N_CYC     = RESULT_READY_STROBE_N_US * CLK_MHZ;
	localparam int SET_CYC      = 16;
	localparam int MEAS_GAP_CYC = 1000;

endpackage

//--- hdl/msr_readout.sv
`timescale 1ns/1ps
// Readout core; clk is the on-chip oscillator and is never driven out [RULE_07]
module msr_readout #(
	parameter int         ADC_W        = 12,
	parameter int         RESULT_READY_STROBE_N_CYC     = msr_pkg::RESULT_READY_STROBE_N_CYC,
	parameter int         SET_CYC      = msr_pkg::SET_CYC,
	parameter int         MEAS_GAP_CYC = msr_pkg::MEAS_GAP_CYC,
	// Identification values are arbitrary
	parameter logic [7:0] ID_A         = 8'h4D,
	parameter logic [7:0] ID_B         = 8'h52,
	parameter logic [7:0] ID_C         = 8'h31
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 clk_en,
	input  wire logic                 scl,
	input  wire logic                 sda_i,
	output logic                      sda_o,
	output logic                      sda_oe,
	output logic                      result_ready_strobe_n_o,
	output logic                      result_ready_strobe_n_oe,
	output logic                      set_pulse,
	output logic                      reset_pulse,
	output logic                      bias_on,
	output logic                      bias_neg,
	output logic                      sample_req,
	input  wire logic                 sample_ack,
	input  wire logic [3*ADC_W-1:0]   sample_data
);

	typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_TX, I_TXACK, I_TXLOAD} msr_bus_e;
	typedef enum logic [2:0] {S_IDLE, S_SET, S_A, S_RST, S_B, S_STORE} msr_seq_e;

	localparam int DW = $clog2(RESULT_READY_STROBE_N_CYC + 1);
	localparam int GW = $clog2(MEAS_GAP_CYC + 1);
	localparam int PW = $clog2(SET_CYC + 1);

	// Link side: only a byte shifter lives on the bus clock
	logic [7:0] link_shift_r;
	always_ff @(posedge scl) begin
		link_shift_r <= {link_shift_r[6:0], sda_i};
	end

	// Pin synchronisers; a few clk cycles of lag is tiny against a 400 kHz bit [RULE_05]
	logic [1:0] scl_sy_r;
	logic [1:0] sda_sy_r;
	logic       scl_d_r;
	logic       sda_d_r;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_sy_r <= 2'h3;
			sda_sy_r <= 2'h3;
			scl_d_r  <= 1'b1;
			sda_d_r  <= 1'b1;
		end else if (clk_en) begin
			scl_sy_r <= {scl_sy_r[0], scl};
			sda_sy_r <= {sda_sy_r[0], sda_i};
			scl_d_r  <= scl_sy_r[1];
			sda_d_r  <= sda_sy_r[1];
		end
	end

	wire scl_s     = scl_sy_r[1];
	wire sda_s     = sda_sy_r[1];
	wire scl_rise  = scl_s & ~scl_d_r;
	wire scl_fall  = ~scl_s & scl_d_r;
	wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
	wire stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

	msr_bus_e   ist_r;
	logic [2:0] bit_r;
	logic [1:0] idx_r;
	logic       rw_r;
	logic       ack_on_r;
	logic [7:0] ptr_r;
	logic [7:0] tx_r;
	logic       sda_oe_r;
	logic [7:0] rd_byte;

	// Only the master starts or clocks a transfer; the shifter holds still
	// between the 8th rise and the next one, so it is safe to read here [RULE_04]
	wire addr_ok   = link_shift_r[7:1] == msr_pkg::SLAVE_ADDR; // [RULE_09]
	wire byte_done = clk_en & (ist_r == I_RX) & scl_rise & (bit_r == 3'h7);
	wire wr_stb    = byte_done & (idx_r == 2'h2) & ~rw_r;
	wire host_busy = ist_r != I_IDLE;
	wire rd_done   = clk_en & (ist_r == I_TXACK) & scl_rise;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ist_r    <= I_IDLE;
			bit_r    <= 3'h0;
			idx_r    <= 2'h0;
			rw_r     <= 1'b0;
			ack_on_r <= 1'b0;
			ptr_r    <= 8'h00;
			tx_r     <= 8'h00;
			sda_oe_r <= 1'b0;
		end else if (clk_en) begin
			if (start_det) begin
				ist_r    <= I_RX;
				bit_r    <= 3'h0;
				idx_r    <= 2'h0;
				sda_oe_r <= 1'b0;
			end else if (stop_det) begin
				ist_r    <= I_IDLE;
				sda_oe_r <= 1'b0;
			end else begin
				case (ist_r)
					I_RX: if (scl_rise) begin
						bit_r <= bit_r + 3'h1;
						if (bit_r == 3'h7) begin
							if (idx_r == 2'h0 && !addr_ok) begin
								ist_r <= I_IDLE; // [RULE_04]
							end else begin
								ist_r    <= I_ACK;
								ack_on_r <= 1'b0;
								if (idx_r == 2'h0)
									rw_r <= link_shift_r[0];
								if (idx_r == 2'h1)
									ptr_r <= link_shift_r;
								if (idx_r == 2'h2)
									ptr_r <= ptr_r + 8'h01;
								else
									idx_r <= idx_r + 2'h1;
							end
						end
					end
					I_ACK: if (scl_fall) begin
						if (!ack_on_r) begin
							ack_on_r <= 1'b1;
							sda_oe_r <= 1'b1;
						end else if (rw_r) begin
							tx_r     <= rd_byte;
							sda_oe_r <= ~rd_byte[7];
							bit_r    <= 3'h1;
							ist_r    <= I_TX;
						end else begin
							sda_oe_r <= 1'b0;
							bit_r    <= 3'h0;
							ist_r    <= I_RX;
						end
					end
					I_TX: if (scl_fall) begin
						if (bit_r == 3'h0) begin
							sda_oe_r <= 1'b0;
							ist_r    <= I_TXACK;
						end else begin
							sda_oe_r <= ~tx_r[3'h7 - bit_r];
							bit_r    <= bit_r + 3'h1;
						end
					end
					I_TXACK: if (scl_rise) begin
						ptr_r <= ptr_r + 8'h01;
						ist_r <= sda_s ? I_IDLE : I_TXLOAD;
					end
					I_TXLOAD: if (scl_fall) begin
						tx_r     <= rd_byte;
						sda_oe_r <= ~rd_byte[7];
						bit_r    <= 3'h1;
						ist_r    <= I_TX;
					end
					default: ist_r <= I_IDLE;
				endcase
			end
		end
	end

	assign sda_o  = 1'b0;
	assign sda_oe = sda_oe_r;

	// Register file
	logic [7:0]        cra_r;
	logic [7:0]        crb_r;
	logic [7:0]        mode_r;
	logic              rdy_r;
	logic signed [15:0] data_r [3];
	msr_seq_e          seq_r;

	wire [7:0] doff     = ptr_r - msr_pkg::REG_DXH;
	wire       in_data  = ptr_r >= msr_pkg::REG_DXH && ptr_r <= msr_pkg::REG_DYL;
	wire [1:0] axis     = doff[2:1];
	wire [15:0] dword   = (axis == 2'h0) ? data_r[0] : (axis == 2'h1) ? data_r[1] : data_r[2];
	wire [7:0] dbyte    = doff[0] ? dword[7:0] : dword[15:8];
	wire [7:0] stat_b   = {6'h00, seq_r == S_STORE, rdy_r};

	assign rd_byte = in_data                     ? dbyte :
	                 ptr_r == msr_pkg::REG_CRA  ? cra_r :
	                 ptr_r == msr_pkg::REG_CRB  ? crb_r :
	                 ptr_r == msr_pkg::REG_MODE ? mode_r :
	                 ptr_r == msr_pkg::REG_STAT ? stat_b :
	                 ptr_r == msr_pkg::REG_IDA  ? ID_A :
	                 ptr_r == msr_pkg::REG_IDB  ? ID_B :
	                 ptr_r == msr_pkg::REG_IDC  ? ID_C : 8'h00;

	wire [1:0] ms_field = cra_r[msr_pkg::MS_LSB +: 2]; // [RULE_10]
	wire [1:0] md_field = mode_r[1:0];

	// Measurement sequencer
	logic [PW-1:0]     pw_r;
	logic [GW-1:0]     gap_r;
	logic              st_r;
	logic              neg_r;
	logic [3*ADC_W-1:0] s1_r;
	logic [3*ADC_W-1:0] s2_r;
	logic signed [15:0] s1e [3];
	logic signed [15:0] s2e [3];
	logic signed [15:0] res [3];

	// Host traffic always wins: no new measurement and no result update mid-frame [RULE_06]
	wire go        = !host_busy && (md_field == msr_pkg::MD_SINGLE ||
	                 (md_field == msr_pkg::MD_CONT && gap_r == '0));
	wire store_evt = clk_en & (seq_r == S_STORE) & ~host_busy;
	wire pw_done   = pw_r == '0;
	wire st_sel    = ms_field == msr_pkg::MS_POS || ms_field == msr_pkg::MS_NEG; // [RULE_02]

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_axis
			assign s1e[g] = 16'(signed'(s1_r[g*ADC_W +: ADC_W]));
			assign s2e[g] = 16'(signed'(s2_r[g*ADC_W +: ADC_W]));
			// Self test keeps biased minus ambient; normal mode halves set minus reset
			assign res[g] = st_r ? s2e[g] - s1e[g] : (s1e[g] - s2e[g]) >>> 1; // [RULE_03]
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			seq_r <= S_IDLE;
			pw_r  <= '0;
			gap_r <= '0;
			st_r  <= 1'b0;
			neg_r <= 1'b0;
			s1_r  <= '0;
			s2_r  <= '0;
		end else if (clk_en) begin
			if (gap_r != '0 && seq_r == S_IDLE)
				gap_r <= gap_r - GW'(1);
			case (seq_r)
				S_IDLE: if (go) begin
					st_r  <= st_sel;
					neg_r <= ms_field == msr_pkg::MS_NEG;
					pw_r  <= PW'(SET_CYC - 1);
					seq_r <= S_SET;
				end
				S_SET: if (pw_done) seq_r <= S_A; else pw_r <= pw_r - PW'(1);
				S_A: if (sample_ack) begin
					s1_r  <= sample_data;
					pw_r  <= PW'(SET_CYC - 1);
					seq_r <= S_RST;
				end
				S_RST: if (pw_done) seq_r <= S_B; else pw_r <= pw_r - PW'(1);
				S_B: if (sample_ack) begin
					s2_r  <= sample_data;
					seq_r <= S_STORE;
				end
				S_STORE: if (!host_busy) begin
					gap_r <= GW'(MEAS_GAP_CYC);
					seq_r <= S_IDLE;
				end
				default: seq_r <= S_IDLE;
			endcase
		end
	end

	assign set_pulse   = seq_r == S_SET; // [RULE_03]
	assign reset_pulse = !st_r && seq_r == S_RST;
	assign bias_on     = st_r && (seq_r == S_RST || seq_r == S_B); // [RULE_02]
	assign bias_neg    = bias_on && neg_r;
	assign sample_req  = seq_r == S_A || seq_r == S_B;

	wire data_rd = rd_done && in_data;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cra_r  <= msr_pkg::CRA_RST;
			crb_r  <= msr_pkg::CRB_RST;
			mode_r <= msr_pkg::MODE_RST;
			rdy_r  <= 1'b0;
			for (int i = 0; i < 3; i++)
				data_r[i] <= 16'h0000;
		end else if (clk_en) begin
			if (wr_stb && ptr_r == msr_pkg::REG_CRA)
				cra_r <= link_shift_r & msr_pkg::CRA_MASK;
			if (wr_stb && ptr_r == msr_pkg::REG_CRB)
				crb_r <= link_shift_r;
			if (wr_stb && ptr_r == msr_pkg::REG_MODE)
				mode_r <= link_shift_r & msr_pkg::MODE_MASK;
			else if (store_evt && md_field == msr_pkg::MD_SINGLE)
				mode_r <= {6'h00, msr_pkg::MD_IDLE};
			// A store in the same cycle as a data read keeps the flag set
			rdy_r <= store_evt | (rdy_r & ~data_rd);
			if (store_evt) begin
				for (int i = 0; i < 3; i++)
					data_r[i] <= res[i];
			end
		end
	end

	// Data-ready: open drain, pulled high outside, driven low RESULT_READY_STROBE_N_CYC cycles
	logic [DW-1:0] dr_r;
	logic          dr_oe_r;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dr_r    <= '0;
			dr_oe_r <= 1'b0;
		end else if (clk_en) begin
			if (store_evt) begin // [RULE_01] [RULE_11]
				dr_r    <= DW'(RESULT_READY_STROBE_N_CYC - 1);
				dr_oe_r <= 1'b1;
			end else if (dr_oe_r) begin
				if (dr_r == '0)
					dr_oe_r <= 1'b0;
				else
					dr_r <= dr_r - DW'(1);
			end
		end
	end

	assign result_ready_strobe_n_o  = 1'b0;
	assign result_ready_strobe_n_oe = dr_oe_r;

	a_result_ready_strobe_n_follows_store: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_01]
		store_evt |=> result_ready_strobe_n_oe && dr_r == DW'(RESULT_READY_STROBE_N_CYC - 1))
		else $error("data-ready not driven after store");

	a_result_ready_strobe_n_ends_at_zero: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_01]
		$fell(result_ready_strobe_n_oe) |-> $past(dr_r) == '0)
		else $error("data-ready released early");

	a_selftest_stores: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_11]
		store_evt && st_r |=> result_ready_strobe_n_oe && rdy_r)
		else $error("self test completion not signalled");

	a_bias_polarity: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_02]
		bias_on |-> neg_r == bias_neg && st_r && !reset_pulse)
		else $error("bias polarity or mode wrong");

	a_set_before_sample: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
		$rose(sample_req) && seq_r == S_A |-> $past(set_pulse))
		else $error("ambient sample without set pulse");

	a_selftest_diff: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
		store_evt && st_r |=> data_r[0] == $past(s2e[0] - s1e[0]))
		else $error("self test result is not biased minus ambient");

	a_store_not_busy: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_06]
		seq_r == S_STORE && host_busy && clk_en |=> seq_r == S_STORE && $stable(data_r[0]))
		else $error("result stored during host frame");

	a_addr_ack_match: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_09]
		byte_done && idx_r == 2'h0 |=> (ist_r == I_ACK) == $past(addr_ok))
		else $error("address acknowledge mismatch");

	a_stop_releases: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_04]
		clk_en && stop_det |=> !sda_oe && ist_r == I_IDLE)
		else $error("data line held after stop");

endmodule

//--- verif/msr_i2c_master.sv
`timescale 1ns/1ps
// Bus master: every frame is started and clocked from here
module msr_i2c_master (
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	logic lclk;

	initial begin
		lclk = 1'b0;
		scl = 1'b1;
		sda_low = 1'b0;
		#5;
		forever #24 lclk = ~lclk;
	end

	// Long low phase leaves room for the slave's input synchroniser
	task automatic bit_io(input logic b, output logic r);
		sda_low = ~b;
		@(posedge lclk);
		@(posedge lclk);
		scl = 1'b1;
		@(negedge lclk);
		r = sda;
		scl = 1'b0;
		#12;
	endtask

	task automatic start();
		sda_low = 1'b0;
		scl = 1'b1;
		@(posedge lclk);
		sda_low = 1'b1;
		@(posedge lclk);
		scl = 1'b0;
		#12;
	endtask

	// Clock stands still high once the frame is over
	task automatic stop();
		sda_low = 1'b1;
		@(posedge lclk);
		@(posedge lclk);
		scl = 1'b1;
		@(posedge lclk);
		sda_low = 1'b0;
		@(posedge lclk);
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		d = 8'h00;
		for (int i = 0; i < 8; i++) begin
			bit_io(1'b1, r);
			d = {d[6:0], r};
		end
		bit_io(last, r);
	endtask
endmodule

//--- verif/magnetometer_selftest_readout_tb.sv
`timescale 1ns/1ps
module magnetometer_selftest_readout_tb;
	localparam int RESULT_READY_STROBE_N_N = 20;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        clk_en = 1'b1;
	logic        sample_ack = 1'b0;
	logic [35:0] sample_data = 36'h0;
	logic [35:0] s_prev, s_last;
	logic [1:0]  b_prev, b_last;
	int          sp_n = 0;
	int          rp_n = 0;
	logic [15:0] c_prev, c_last;
	wire         scl, m_low, sda_oe, sda_o, st_o, st_oe, set_p, rst_p, bias_on, bias_neg, req;
	wire         sda = (sda_oe ? sda_o : 1'b1) & ~m_low;
	wire         rdy_n = st_oe ? st_o : 1'b1;
	int          n_errors = 0;
	int          checked = 0;

	always #4 clk = ~clk;

	msr_i2c_master m (.sda(sda), .scl(scl), .sda_low(m_low));

	msr_readout #(.RESULT_READY_STROBE_N_CYC(RESULT_READY_STROBE_N_N), .MEAS_GAP_CYC(50)) dut (
		.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .scl(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .result_ready_strobe_n_o(st_o),
		.result_ready_strobe_n_oe(st_oe), .set_pulse(set_p), .reset_pulse(rst_p),
		.bias_on(bias_on), .bias_neg(bias_neg), .sample_req(req),
		.sample_ack(sample_ack), .sample_data(sample_data));

	// Sensor side answers after a random number of cycles
	always @(posedge clk) begin
		#1;
		// Pulse widths seen since the previous sample
		if (set_p === 1'b1) sp_n++;
		if (rst_p === 1'b1) rp_n++;
		if (sample_ack) begin
			sample_ack = 1'b0;
		end else if (req === 1'b1 && $urandom_range(0, 2) == 0) begin
			sample_data = 36'({$urandom, $urandom});
			sample_ack = 1'b1;
			s_prev = s_last;
			s_last = sample_data;
			b_prev = b_last;
			b_last = {bias_on, bias_neg};
			c_prev = c_last;
			c_last = {8'(sp_n), 8'(rp_n)};
			sp_n = 0;
			rp_n = 0;
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	function automatic logic [15:0] expv(input int ax, input logic st);
		logic signed [15:0] m1;
		logic signed [15:0] m2;
		m1 = {{4{s_prev[ax*12+11]}}, s_prev[ax*12 +: 12]};
		m2 = {{4{s_last[ax*12+11]}}, s_last[ax*12 +: 12]};
		return st ? m2 - m1 : (m1 - m2) >>> 1;
	endfunction

	// Host watches the strobe for the fastest turnaround
	task automatic wait_ready();
		int n;
		n = 0;
		while (rdy_n !== 1'b0 && n < 4000) begin
			@(posedge clk);
			#2;
			n++;
		end
		if (n >= 4000) begin
			n_errors++;
			$display("unexpected at %0t: no ready strobe", $time);
			conclude();
		end
		n = 0;
		while (rdy_n === 1'b0 && n < 100) begin
			@(posedge clk);
			#2;
			n++;
		end
		chk(16'(n), 16'(RESULT_READY_STROBE_N_N), "strobe width");
	endtask

	task automatic rd_check(input logic st);
		logic [7:0] b [6];
		logic       a;
		m.start();
		m.wbyte(8'h3C, a);
		m.wbyte(msr_pkg::REG_DXH, a);
		m.stop();
		m.start();
		m.wbyte(8'h3D, a);
		for (int i = 0; i < 6; i++) begin
			m.rbyte(i == 5, b[i]);
		end
		m.stop();
		for (int i = 0; i < 3; i++) begin
			chk({b[2*i], b[2*i+1]}, expv(i, st), "axis result");
		end
	endtask

	initial begin
		logic [7:0] ad [5];
		logic       a;
		logic [7:0] d;
		logic [1:0] ms;
		void'($urandom(7112));
		repeat (3) @(posedge clk);
		#1 rst_n = 1'b1;
		wait_ready();
		chk({15'h0, b_last[1]}, 16'h0, "bias in normal run");
		chk(c_prev, {8'(msr_pkg::SET_CYC), 8'h00}, "set pulse before ambient");
		chk(c_last, {8'h00, 8'(msr_pkg::SET_CYC)}, "reset pulse in normal run");
		rd_check(1'b0);
		$display("test power_up_single done");
		ad = '{8'h3C, 8'h3D, 8'h3E, 8'h1E, 8'($urandom_range(0, 255))};
		foreach (ad[i]) begin
			m.start();
			m.wbyte(ad[i], a);
			chk({15'h0, a}, {15'h0, ad[i][7:1] == 7'h1E}, "address ack");
			if (a && ad[i][0]) begin
				m.rbyte(1'b1, d);
			end
			m.stop();
		end
		$display("test slave_address done");
		for (int k = 0; k < 2; k++) begin
			ms = k ? msr_pkg::MS_NEG : msr_pkg::MS_POS;
			m.start();
			m.wbyte(8'h3C, a);
			m.wbyte(msr_pkg::REG_CRA, a);
			m.wbyte(msr_pkg::CRA_RST | {6'h00, ms}, a);
			m.wbyte(msr_pkg::CRB_RST, a);
			m.wbyte({6'h00, msr_pkg::MD_SINGLE}, a);
			m.stop();
			wait_ready();
			chk({15'h0, b_prev[1]}, 16'h0, "bias in ambient sample");
			chk(c_prev, {8'(msr_pkg::SET_CYC), 8'h00}, "set pulse in self test");
			chk(c_last, 16'h0000, "no reset pulse in self test");
			chk({14'h0, b_last}, {14'h0, 1'b1, k == 1}, "bias polarity");
			rd_check(1'b1);
			$display("test self_test %0d done", k);
		end
		conclude();
	end
endmodule
